// File: src/secb_top.sv
// counter bank top: AXI4-Lite registers, interrupts, power-loss dump
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module secb_top #(
    parameter int N_CNT = secb_pkg::CNT_NUM
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire secb_pkg::secb_ops_t ops [N_CNT],
    input wire logic [63:0] timestamp,
    input wire logic power_fail,
    output logic [N_CNT-1:0] above_flag,
    output logic [N_CNT-1:0] equal_flag,
    output logic [N_CNT-1:0] below_flag,
    output logic irq,
    output logic nv_wr_valid,
    output logic [4:0] nv_wr_addr,
    output logic [31:0] nv_wr_data
);
    secb_pkg::secb_cfg_t cfg_reg [N_CNT];
    secb_pkg::secb_stat_t stat [N_CNT];
    logic [N_CNT-1:0] ctrl_reg;
    logic [15:0] irq_status_reg;
    logic [15:0] irq_enable_reg;
    logic [N_CNT-1:0] cap_evt;
    logic [N_CNT-1:0] wrap_evt;
    logic [15:0] irq_evt;
    logic [15:0] irq_clr;
    logic [31:0] ctrl_wr_word;
    logic [31:0] irq_en_wr_word;
    logic [15:0] irq_enable_next;

    // write and read channel state
    logic aw_held_reg;
    logic [11:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic aw_held_next;
    logic w_held_next;
    logic bvalid_next;
    logic ar_take;
    logic rvalid_next;

    // write address decode
    logic [2:0] wr_idx;
    logic [4:0] wr_off;
    logic wr_bank;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_enable;
    logic wr_preset;
    logic wr_compare;
    logic wr_hit;

    // read address decode
    logic [2:0] rd_idx;
    logic [4:0] rd_off;
    logic rd_bank;
    secb_pkg::secb_stat_t rd_stat;
    secb_pkg::secb_cfg_t rd_cfg;
    logic [31:0] rd_word;
    logic rd_hit;

    // power-loss dump
    secb_pkg::secb_nv_state_t nv_state_reg;
    secb_pkg::secb_nv_state_t nv_state_next;
    logic pf_prev_reg;
    logic pf_rise;
    logic [4:0] nv_ptr_reg;
    logic [4:0] nv_ptr_next;
    secb_pkg::secb_stat_t nv_stat;
    logic [31:0] nv_word;

    for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
        secb_counter u_cnt (
            .clk(aclk),
            .rst_n(aresetn),
            .enable(ctrl_reg[g]),
            .cfg(cfg_reg[g]),
            .ops(ops[g]),
            .timestamp(timestamp),
            .stat(stat[g]),
            .above(above_flag[g]),
            .equal(equal_flag[g]),
            .below(below_flag[g]),
            .cap_evt(cap_evt[g]),
            .wrap_evt(wrap_evt[g])
        );
    end

    // channel handshakes
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
    assign aw_held_next = wr_fire ? 1'b0 : (aw_held_reg || aw_take);
    assign w_held_next = wr_fire ? 1'b0 : (w_held_reg || w_take);
    assign bvalid_next = wr_fire ? 1'b1 : (bvalid && !bready);
    assign ar_take = arvalid && arready;
    assign rvalid_next = ar_take ? 1'b1 : (rvalid && !rready);

    // write decode from the held address
    assign wr_idx = aw_addr_reg[secb_pkg::IDX_LSB +: secb_pkg::IDX_W];
    assign wr_off = aw_addr_reg[secb_pkg::OFF_W-1:0];
    assign wr_bank = aw_addr_reg[11:secb_pkg::PAGE_LSB] == secb_pkg::BANK_PAGE;
    assign wr_ctrl = aw_addr_reg == secb_pkg::ADDR_CTRL;
    assign wr_clear = aw_addr_reg == secb_pkg::ADDR_IRQ_CLEAR;
    assign wr_enable = aw_addr_reg == secb_pkg::ADDR_IRQ_ENABLE;
    assign wr_preset = wr_bank && wr_off == secb_pkg::OFF_PRESET;
    assign wr_compare = wr_bank && wr_off == secb_pkg::OFF_COMPARE;
    assign wr_hit = wr_ctrl || wr_clear || wr_enable || wr_preset || wr_compare;

    // read decode of live and frozen values
    assign rd_idx = araddr[secb_pkg::IDX_LSB +: secb_pkg::IDX_W];
    assign rd_off = araddr[secb_pkg::OFF_W-1:0];
    assign rd_bank = araddr[11:secb_pkg::PAGE_LSB] == secb_pkg::BANK_PAGE;
    assign rd_stat = stat[rd_idx];
    assign rd_cfg = cfg_reg[rd_idx];
    assign rd_word =
        (araddr == secb_pkg::ADDR_CTRL) ? {{(32-N_CNT){1'b0}}, ctrl_reg} :
        (araddr == secb_pkg::ADDR_IRQ_STATUS) ? {16'h0000, irq_status_reg} :
        (araddr == secb_pkg::ADDR_IRQ_ENABLE) ? {16'h0000, irq_enable_reg} :
        (rd_bank && rd_off == secb_pkg::OFF_PRESET) ? rd_cfg.preset :
        (rd_bank && rd_off == secb_pkg::OFF_COMPARE) ? rd_cfg.compare :
        (rd_bank && rd_off == secb_pkg::OFF_COUNT) ? rd_stat.count :
        (rd_bank && rd_off == secb_pkg::OFF_CAP) ? rd_stat.cap :
        (rd_bank && rd_off == secb_pkg::OFF_TS_LO) ? rd_stat.cap_ts[31:0] :
        (rd_bank && rd_off == secb_pkg::OFF_TS_HI) ? rd_stat.cap_ts[63:32] :
        secb_pkg::CNT_ZERO;
    assign rd_hit = (araddr == secb_pkg::ADDR_CTRL) ||
                    (araddr == secb_pkg::ADDR_IRQ_STATUS) ||
                    (araddr == secb_pkg::ADDR_IRQ_ENABLE) ||
                    (rd_bank && rd_off <= secb_pkg::OFF_TS_HI && rd_off[1:0] == 2'b00);

    // write side of the slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= secb_pkg::RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready <= !aw_held_next;
            wready <= !w_held_next;
            bvalid <= bvalid_next;
            if (wr_fire) begin
                bresp <= wr_hit ? secb_pkg::RESP_OKAY : secb_pkg::RESP_SLVERR;
            end
        end
    end

    // held write payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= awaddr;
            end
            if (w_take) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
        end
    end

    // read side of the slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= secb_pkg::RESP_OKAY;
        end else begin
            arready <= !rvalid_next;
            rvalid <= rvalid_next;
            if (ar_take) begin
                rdata <= rd_word;
                rresp <= rd_hit ? secb_pkg::RESP_OKAY : secb_pkg::RESP_SLVERR;
            end
        end
    end

    // byte-lane merged words for the writable control registers
    assign ctrl_wr_word = secb_pkg::secb_strb({{(32-N_CNT){1'b0}}, ctrl_reg},
                                              w_data_reg, w_strb_reg);
    assign irq_en_wr_word = secb_pkg::secb_strb({16'h0000, irq_enable_reg},
                                                w_data_reg, w_strb_reg);
    assign irq_enable_next = (wr_fire && wr_enable) ? irq_en_wr_word[15:0] : irq_enable_reg;

    // counter enables and interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= '0;
            irq_enable_reg <= '0;
        end else if (wr_fire) begin
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_wr_word[N_CNT-1:0];
            end
            if (wr_enable) begin
                irq_enable_reg <= irq_en_wr_word[15:0];
            end
        end
    end

    // per-counter preset and compare
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_CNT; i++) begin
                cfg_reg[i] <= '0;
            end
        end else if (wr_fire && wr_preset) begin
            cfg_reg[wr_idx].preset <= secb_pkg::secb_strb(cfg_reg[wr_idx].preset,
                                                          w_data_reg, w_strb_reg);
        end else if (wr_fire && wr_compare) begin
            cfg_reg[wr_idx].compare <= secb_pkg::secb_strb(cfg_reg[wr_idx].compare,
                                                           w_data_reg, w_strb_reg);
        end
    end

    // sticky events, a new event wins over a clear
    assign irq_evt = {{(8-N_CNT){1'b0}}, wrap_evt, {(8-N_CNT){1'b0}}, cap_evt};
    assign irq_clr = (wr_fire && wr_clear) ? (w_data_reg[15:0] & {{8{w_strb_reg[1]}},
                                                               {8{w_strb_reg[0]}}})
                                           : 16'h0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_evt;
            // mask with the new enable so irq tracks status and mask together
            irq <= |(((irq_status_reg & ~irq_clr) | irq_evt) & irq_enable_next);
        end
    end

    // dump word select: count, capture, stamp low, stamp high
    assign pf_rise = power_fail && !pf_prev_reg;
    assign nv_stat = stat[nv_ptr_reg[4:2]];
    assign nv_word = (nv_ptr_reg[1:0] == secb_pkg::NV_SUB_COUNT) ? nv_stat.count :
                     (nv_ptr_reg[1:0] == secb_pkg::NV_SUB_CAP) ? nv_stat.cap :
                     (nv_ptr_reg[1:0] == secb_pkg::NV_SUB_TS_LO) ? nv_stat.cap_ts[31:0] :
                     nv_stat.cap_ts[63:32];

    always_comb begin
        nv_state_next = nv_state_reg;
        nv_ptr_next = nv_ptr_reg;
        case (nv_state_reg)
            secb_pkg::NV_IDLE: begin
                if (pf_rise) begin
                    nv_state_next = secb_pkg::NV_DUMP;
                    nv_ptr_next = '0;
                end
            end
            secb_pkg::NV_DUMP: begin
                nv_ptr_next = nv_ptr_reg + 5'h01;
                if (nv_ptr_reg == secb_pkg::NV_LAST) begin
                    nv_state_next = secb_pkg::NV_IDLE;
                end
            end
            default: begin
                nv_state_next = secb_pkg::NV_IDLE;
            end
        endcase
    end

    // dump outputs, one word per cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_state_reg <= secb_pkg::NV_IDLE;
            nv_ptr_reg <= '0;
            pf_prev_reg <= 1'b0;
            nv_wr_valid <= 1'b0;
            nv_wr_addr <= '0;
            nv_wr_data <= '0;
        end else begin
            nv_state_reg <= nv_state_next;
            nv_ptr_reg <= nv_ptr_next;
            pf_prev_reg <= power_fail;
            nv_wr_valid <= nv_state_reg == secb_pkg::NV_DUMP;
            nv_wr_addr <= nv_ptr_reg;
            nv_wr_data <= nv_word;
        end
    end

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
            ##1 irq == |(irq_status_reg & irq_enable_reg);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
    property p_dump;
        @(posedge aclk) disable iff (!aresetn)
            (nv_state_reg == secb_pkg::NV_IDLE && pf_rise) |=> ##1 nv_wr_valid [*8];
    endproperty
    a_dump: assert property (p_dump) else $error("power-loss dump stalled");
endmodule : secb_top

// File: inc/secb_pkg.sv
// constants, types and helpers for the signed event counter bank
package secb_pkg;
    localparam int CNT_NUM = 8;
    localparam int CNT_W = 32;
    localparam int TS_W = 64;
    localparam int ADDR_W = 12;
    localparam int IRQ_W = 16;
    localparam int IRQ_CAP_LSB = 0;
    localparam int IRQ_WRAP_LSB = 8;
    // register map, byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h008;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00c;
    localparam logic [3:0] BANK_PAGE = 4'h1;
    localparam int PAGE_LSB = 8;
    localparam int IDX_LSB = 5;
    localparam int IDX_W = 3;
    localparam int OFF_W = 5;
    localparam logic [4:0] OFF_PRESET = 5'h00;
    localparam logic [4:0] OFF_COMPARE = 5'h04;
    localparam logic [4:0] OFF_COUNT = 5'h08;
    localparam logic [4:0] OFF_CAP = 5'h0c;
    localparam logic [4:0] OFF_TS_LO = 5'h10;
    localparam logic [4:0] OFF_TS_HI = 5'h14;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // count limits
    localparam logic [31:0] CNT_MAX = 32'h7fffffff;
    localparam logic [31:0] CNT_MIN = 32'h80000000;
    localparam logic [31:0] CNT_ONE = 32'h00000001;
    localparam logic [31:0] CNT_ZERO = 32'h00000000;
    // power-loss dump: four words per counter
    localparam int NV_ADDR_W = 5;
    localparam logic [1:0] NV_SUB_COUNT = 2'h0;
    localparam logic [1:0] NV_SUB_CAP = 2'h1;
    localparam logic [1:0] NV_SUB_TS_LO = 2'h2;
    localparam logic [4:0] NV_LAST = 5'h1f;

    typedef struct packed {
        logic inc;
        logic dec;
        logic blk;
        logic lps;
        logic rst;
        logic frz_rst;
        logic frz_cnt;
    } secb_ops_t;

    typedef struct packed {
        logic [31:0] preset;
        logic [31:0] compare;
    } secb_cfg_t;

    typedef struct packed {
        logic [31:0] count;
        logic [31:0] cap;
        logic [63:0] cap_ts;
    } secb_stat_t;

    typedef enum logic [0:0] {
        NV_IDLE = 1'b0,
        NV_DUMP = 1'b1
    } secb_nv_state_t;

    // byte-lane merge of a bus write
    function automatic logic [31:0] secb_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : secb_strb
endpackage : secb_pkg

// File: src/secb_rise.sv
// rising-edge detector for a group of operand inputs
`timescale 1ns/1ns
module secb_rise #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] sig,
    output logic [W-1:0] rise
);
    logic [W-1:0] prev_reg;

    // previous level of each input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sig;
        end
    end

    assign rise = sig & ~prev_reg;
endmodule : secb_rise

// File: src/secb_counter.sv
// one signed up/down event counter with compare flags and capture
`timescale 1ns/1ns
module secb_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire secb_pkg::secb_cfg_t cfg,
    input wire secb_pkg::secb_ops_t ops,
    input wire logic [63:0] timestamp,
    output secb_pkg::secb_stat_t stat,
    output logic above,
    output logic equal,
    output logic below,
    output logic cap_evt,
    output logic wrap_evt
);
    logic [7:0] rise;
    logic r_en;
    secb_pkg::secb_ops_t r;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] load_val;
    logic [31:0] counted;
    logic run;
    logic step_up;
    logic step_dn;
    logic loading;
    logic cap_cmd;
    logic wrap_next;
    logic [31:0] cap_reg;
    logic [63:0] cap_ts_reg;

    secb_rise #(.W(8)) u_rise (
        .clk(clk),
        .rst_n(rst_n),
        .sig({enable, ops}),
        .rise(rise)
    );

    assign r_en = rise[7];
    assign r = rise[6:0];
    assign run = enable && !ops.blk;
    // preset or zero by select level
    assign load_val = ops.lps ? cfg.preset : secb_pkg::CNT_ZERO;
    assign step_up = r.inc && !r.dec;
    assign step_dn = r.dec && !r.inc;
    assign counted = step_up ? count_reg + secb_pkg::CNT_ONE :
                     step_dn ? count_reg - secb_pkg::CNT_ONE : count_reg;
    assign loading = r.rst || r.frz_rst;
    assign count_next = !enable ? count_reg :
                        r_en ? load_val :
                        ops.blk ? count_reg :
                        loading ? load_val :
                        r.lps ? cfg.preset : counted;
    assign cap_cmd = run && !r_en && (r.frz_rst || r.frz_cnt);
    assign wrap_next = run && !r_en && !loading && !r.lps &&
                       ((step_up && count_reg == secb_pkg::CNT_MAX) ||
                        (step_dn && count_reg == secb_pkg::CNT_MIN));

    // running count and events
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            cap_evt <= 1'b0;
            wrap_evt <= 1'b0;
        end else begin
            count_reg <= count_next;
            cap_evt <= cap_cmd;
            wrap_evt <= wrap_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_reg <= '0;
            cap_ts_reg <= '0;
        end else if (cap_cmd) begin
            cap_reg <= count_reg;
            cap_ts_reg <= timestamp;
        end
    end

    // flags follow the new count, blanked when blocked
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            above <= 1'b0;
            equal <= 1'b0;
            below <= 1'b0;
        end else begin
            above <= run && ($signed(count_next) > $signed(cfg.compare));
            equal <= run && (count_next == cfg.compare);
            below <= run && ($signed(count_next) < $signed(cfg.compare));
        end
    end

    // one driver for the whole status carrier
    assign stat = {count_reg, cap_reg, cap_ts_reg};

    property p_flags_one;
        @(posedge clk) disable iff (!rst_n) run |=> $onehot({above, equal, below});
    endproperty
    a_flags_one: assert property (p_flags_one) else $error("flags not exclusive");
    property p_blk;
        @(posedge clk) disable iff (!rst_n) ops.blk |=> !above && !equal && !below;
    endproperty
    a_blk: assert property (p_blk) else $error("flag active while blocked");
    property p_inc;
        @(posedge clk) disable iff (!rst_n)
            (run && !r_en && !loading && !r.lps && r.inc && !r.dec)
            |=> count_reg == $past(count_reg) + secb_pkg::CNT_ONE;
    endproperty
    a_inc: assert property (p_inc) else $error("increment missed");
    property p_dec_wrap;
        @(posedge clk) disable iff (!rst_n)
            (run && !r_en && !loading && !r.lps && step_dn && count_reg == secb_pkg::CNT_MIN)
            |=> count_reg == secb_pkg::CNT_MAX;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");
    property p_both;
        @(posedge clk) disable iff (!rst_n)
            (run && !r_en && !loading && !r.lps && r.inc && r.dec) |=> $stable(count_reg);
    endproperty
    a_both: assert property (p_both) else $error("count moved on both edges");
    property p_en_load;
        @(posedge clk) disable iff (!rst_n)
            r_en |=> count_reg == ($past(ops.lps) ? $past(cfg.preset) : secb_pkg::CNT_ZERO);
    endproperty
    a_en_load: assert property (p_en_load) else $error("enable load wrong");
    property p_lps;
        @(posedge clk) disable iff (!rst_n)
            (run && !r_en && !loading && r.lps) |=> count_reg == $past(cfg.preset);
    endproperty
    a_lps: assert property (p_lps) else $error("preset load missed");
    property p_frz;
        @(posedge clk) disable iff (!rst_n)
            cap_cmd |=> stat.cap == $past(count_reg) && stat.cap_ts == $past(timestamp);
    endproperty
    a_frz: assert property (p_frz) else $error("capture wrong");
    property p_frz_rst;
        @(posedge clk) disable iff (!rst_n)
            (run && !r_en && r.frz_rst && !ops.lps) |=> count_reg == secb_pkg::CNT_ZERO;
    endproperty
    a_frz_rst: assert property (p_frz_rst) else $error("freeze reset not cleared");
endmodule : secb_counter

// File: tb/secb_ops_model.sv
// operand source model: the relay logic that drives the counter operands
`timescale 1ns/1ns
module secb_ops_model #(
    parameter int N = 8
) (
    input wire logic aclk,
    output secb_pkg::secb_ops_t ops [N]
);
    logic [6:0] lv [N] = '{default: 7'h00};

    // plain operand levels packed into the design's carrier
    always_comb begin
        for (int i = 0; i < N; i++) begin
            ops[i] = secb_pkg::secb_ops_t'(lv[i]);
        end
    end

    // raise or drop operand levels just after an edge
    task automatic lvl(input int i, input logic [6:0] m, input logic v);
        @(posedge aclk);
        lv[i] <= v ? (lv[i] | m) : (lv[i] & ~m);
    endtask : lvl

    // one cycle high: exactly one rising transition
    task automatic pulse(input int i, input logic [6:0] m);
        lvl(i, m, 1'b1);
        lvl(i, m, 1'b0);
    endtask : pulse
endmodule : secb_ops_model

// File: tb/tb_top.sv
// self-checking bench for the signed event counter bank
`timescale 1ns/1ns
module tb_top;
    localparam logic [6:0] INC = 7'h40, DEC = 7'h20, BLK = 7'h10, LPS = 7'h08;
    localparam logic [6:0] RST = 7'h04, FR = 7'h02, FC = 7'h01;
    logic aclk = 1'b0, aresetn = 1'b0, power_fail = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [63:0] timestamp = 64'h0123456789abcdef;
    logic awready, wready, bvalid, arready, rvalid, irq, nv_wr_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, nv_wr_data, rd_q, nv_cap;
    logic [4:0] nv_wr_addr;
    logic [7:0] above_flag, equal_flag, below_flag;
    logic [1:0] rsp_q;
    secb_pkg::secb_ops_t ops [8];
    int failures = 0;
    int n_tests = 0;
    int n_nv = 0;

    initial begin
        forever #2 aclk = ~aclk;
    end

    secb_top i_secb_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .ops, .timestamp, .power_fail, .above_flag, .equal_flag, .below_flag, .irq,
        .nv_wr_valid, .nv_wr_addr, .nv_wr_data);
    secb_ops_model i_secb_ops_model (.aclk, .ops);

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // AXI4-Lite write, response code kept in rsp_q
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp_q = bresp;
        bready <= 1'b0;
    endtask : wr

    // AXI4-Lite read into rd_q and rsp_q
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_q = rdata;
        rsp_q = rresp;
        rready <= 1'b0;
    endtask : rd

    function automatic logic [11:0] ca(input logic [2:0] n, input logic [4:0] off);
        return {secb_pkg::BANK_PAGE, n, off};
    endfunction : ca

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_q, e);
    endtask : rc

    task automatic rcn(input logic [2:0] n, input logic [31:0] e);
        rc(ca(n, secb_pkg::OFF_COUNT), e);
    endtask : rcn

    // flags of counter 0 as above, equal, below
    task automatic fl(input logic [2:0] e);
        chk({29'h0, above_flag[0], equal_flag[0], below_flag[0]}, {29'h0, e});
    endtask : fl

    task automatic pu(input logic [6:0] m);
        i_secb_ops_model.pulse(0, m);
    endtask : pu

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        failures++;
        finish_test;
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        wr(ca(0, secb_pkg::OFF_COMPARE), 32'h2);
        wr(ca(0, secb_pkg::OFF_PRESET), 32'h5);
        wr(ca(7, secb_pkg::OFF_PRESET), 32'h9);
        i_secb_ops_model.lvl(0, LPS, 1'b1);
        wr(secb_pkg::ADDR_CTRL, 32'h1);
        i_secb_ops_model.lvl(0, LPS, 1'b0);
        rcn(0, 32'h5);
        fl(3'b100);
        wr(secb_pkg::ADDR_CTRL, 32'h81);
        rcn(7, 32'h0);
        pu(RST);
        rcn(0, 32'h0);
        pu(INC);
        i_secb_ops_model.lvl(0, INC, 1'b1);
        repeat (5) @(posedge aclk);
        i_secb_ops_model.lvl(0, INC, 1'b0);
        rcn(0, 32'h2);
        fl(3'b010);
        pu(INC | DEC);
        rcn(0, 32'h2);
        rcn(7, 32'h0);
        i_secb_ops_model.lvl(7, LPS, 1'b1);
        rcn(7, 32'h9);
        pu(DEC);
        rcn(0, 32'h1);
        fl(3'b001);
        i_secb_ops_model.lvl(0, BLK, 1'b1);
        pu(INC);
        rcn(0, 32'h1);
        fl(3'b000);
        i_secb_ops_model.lvl(0, BLK, 1'b0);
        pu(FC);
        rc(ca(0, secb_pkg::OFF_CAP), 32'h1);
        rcn(0, 32'h1);
        rc(ca(0, secb_pkg::OFF_TS_LO), 32'h89abcdef);
        rc(ca(0, secb_pkg::OFF_TS_HI), 32'h01234567);
        pu(INC);
        pu(FR);
        rc(ca(0, secb_pkg::OFF_CAP), 32'h2);
        rcn(0, 32'h0);
        wr(ca(0, secb_pkg::OFF_PRESET), secb_pkg::CNT_MAX);
        pu(LPS);
        rcn(0, secb_pkg::CNT_MAX);
        pu(INC);
        rcn(0, secb_pkg::CNT_MIN);
        pu(DEC);
        rcn(0, secb_pkg::CNT_MAX);
        rc(secb_pkg::ADDR_IRQ_STATUS, 32'h101);
        chk({31'h0, irq}, 32'h0);
        wr(secb_pkg::ADDR_IRQ_ENABLE, 32'h100);
        rc(secb_pkg::ADDR_IRQ_ENABLE, 32'h100);
        chk({31'h0, irq}, 32'h1);
        wr(secb_pkg::ADDR_IRQ_CLEAR, 32'h101);
        rc(secb_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(12'h010);
        chk({30'h0, rsp_q}, {30'h0, secb_pkg::RESP_SLVERR});
        wr(ca(0, secb_pkg::OFF_COUNT), 32'h0);
        chk({30'h0, rsp_q}, {30'h0, secb_pkg::RESP_SLVERR});
        rcn(0, secb_pkg::CNT_MAX);
        @(posedge aclk);
        power_fail <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            if (nv_wr_valid === 1'b1) begin
                n_nv++;
                if (nv_wr_addr === 5'h01) nv_cap = nv_wr_data;
            end
        end
        chk(n_nv, 32);
        chk(nv_cap, 32'h2);
        finish_test;
    end
endmodule : tb_top
